// >>> serial_card_ctrl.sv
// Purpose: Control/status registers, clock pin control and byte shifters
//          of a serial interface with smart-card mode, APB slave.
// Assumes: link_clk and rxd are asynchronous; shifting uses the
//          sampled rising edges of link_clk.
// Notes:   Frame is start bit, 8 data bits LSB first, one stop bit.
//
// Behaviour
// - Transmit interrupt enable gates empty request
// - Receive interrupt enable gates receive, error requests
// - Transmit only while transmit enable set
// - Receive only while receive enable set
// - Card mode clock select: off, out, reserved
// - GSM style: low, clock, high, clock
// - GSM clock pin switchable at any time
// - Writing one to status flags does nothing
// - Empty flag set when disabled or loaded
// - Empty cleared by read-then-zero or engine write
// - Full flag set on good received byte
// - Full cleared by read-then-zero or engine read
// - Receive disable leaves full flag unchanged
// - Reset: empty one, full zero, control zero
// - Normal status meanings when card select zero
// - Card select one enters smart-card mode
`include "serial_card_defines.svh"

module serial_card_ctrl
    import serial_card_pkg::*;
#(
    parameter int CLK_DIV = `CLK_DIV_HALF
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_clk,
    input  wire logic        rxd,
    output logic             txd,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        engine_tx_wr,
    input  wire logic [7:0]  engine_tx_data,
    input  wire logic        engine_rx_rd,
    output logic      [7:0]  engine_rx_data,
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             rx_error_irq,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    byte_t        control_reg;
    byte_t        card_mode_reg;
    byte_t        tx_holding;
    byte_t        rx_holding;
    logic         tx_buf_empty;
    logic         rx_buf_full;
    logic         framing_flag;
    logic [2:0]   armed;
    logic [2:0]   irq_status;
    logic [2:0]   irq_enable;
    logic [1:0]   lclk_sync;
    logic [1:0]   rxd_sync;
    logic         lclk_prev;
    logic         bit_tick;
    logic         card_mode;
    logic         gsm_style;
    logic         tx_on;
    logic         rx_on;
    logic [1:0]   clk_sel;
    logic         wr_acc;
    logic         rd_acc;
    logic         tx_load;
    logic         rx_done_ok;
    logic         rx_done_bad;
    logic         tx_empty_q;
    byte_t        status_view;
    shift_state_t tx_state;
    shift_state_t rx_state;
    byte_t        tx_shifter;
    byte_t        rx_shifter;
    logic [2:0]   tx_bits;
    logic [2:0]   rx_bits;
    logic [15:0]  div_cnt;
    logic         sck_gen;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction : hit

    assign tx_on     = control_reg[`CTL_TX_ON];
    assign rx_on     = control_reg[`CTL_RX_ON];
    assign clk_sel   = control_reg[`CTL_CLK_HI:`CTL_CLK_LO];
    assign card_mode = card_mode_reg[`MODE_CARD_SEL];
    assign gsm_style = card_mode_reg[`MODE_GSM];
    assign wr_acc    = psel && penable && pwrite;
    assign rd_acc    = psel && penable && !pwrite;
    assign pready    = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // APB: read data is loaded in the setup cycle, so zero wait states
    always_comb
    begin
        status_view = 8'h00;
        status_view[`ST_TX_EMPTY] = tx_buf_empty;
        status_view[`ST_RX_FULL]  = rx_buf_full;
        // Framing bit means something else in card mode; reads zero there
        status_view[`ST_FRAMING]  = framing_flag && !card_mode;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (hit(paddr, `OFF_CONTROL))
                prdata[7:0] <= control_reg;
            else if (hit(paddr, `OFF_STATUS))
                prdata[7:0] <= status_view;
            else if (hit(paddr, `OFF_TX_HOLD))
                prdata[7:0] <= tx_holding;
            else if (hit(paddr, `OFF_RX_HOLD))
                prdata[7:0] <= rx_holding;
            else if (hit(paddr, `OFF_CARD_MODE))
                prdata[7:0] <= card_mode_reg;
            else if (hit(paddr, `OFF_IRQ_STAT))
                prdata[2:0] <= irq_status;
            else if (hit(paddr, `OFF_IRQ_EN))
                prdata[2:0] <= irq_enable;
            else if (!hit(paddr, `OFF_IRQ_CLR))
                pslverr <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_reg   <= `CONTROL_RESET;
            card_mode_reg <= 8'h00;
            irq_enable    <= 3'h0;
        end
        else if (wr_acc)
        begin
            // Clock select may change at any time; no disable needed
            if (hit(paddr, `OFF_CONTROL))
                control_reg <= pwdata[7:0];
            else if (hit(paddr, `OFF_CARD_MODE))
                card_mode_reg <= {6'h00, pwdata[1:0]};
            else if (hit(paddr, `OFF_IRQ_EN))
                irq_enable <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_holding <= 8'h00;
        else if (engine_tx_wr)
            tx_holding <= engine_tx_data;
        else if (wr_acc && hit(paddr, `OFF_TX_HOLD))
            tx_holding <= pwdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags; a 0 write clears only bits seen as 1 by a prior read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            armed <= 3'h0;
        else if (rd_acc && hit(paddr, `OFF_STATUS))
            // Arm from what the read returned, not from later flags
            armed <= {prdata[`ST_TX_EMPTY], prdata[`ST_RX_FULL],
                      prdata[`ST_FRAMING]};
        else if (wr_acc && hit(paddr, `OFF_STATUS))
            armed <= 3'h0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_buf_empty <= 1'b1;
        else if (!tx_on || tx_load)
            tx_buf_empty <= 1'b1;
        else if (engine_tx_wr)
            tx_buf_empty <= 1'b0;
        else if (wr_acc && hit(paddr, `OFF_STATUS) && armed[2]
                 && !pwdata[`ST_TX_EMPTY])
            tx_buf_empty <= 1'b0;
    end

    // Receive enable has no hand here, so disabling keeps the flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_buf_full <= 1'b0;
        else if (rx_done_ok)
            rx_buf_full <= 1'b1;
        else if (engine_rx_rd)
            rx_buf_full <= 1'b0;
        else if (wr_acc && hit(paddr, `OFF_STATUS) && armed[1]
                 && !pwdata[`ST_RX_FULL])
            rx_buf_full <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            framing_flag <= 1'b0;
        else if (rx_done_bad)
            framing_flag <= 1'b1;
        else if (wr_acc && hit(paddr, `OFF_STATUS) && armed[0]
                 && !pwdata[`ST_FRAMING])
            framing_flag <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Requests and the summary interrupt
    assign tx_irq       = tx_buf_empty && control_reg[`CTL_TX_IRQ_EN];
    assign rx_irq       = rx_buf_full && control_reg[`CTL_RX_IRQ_EN];
    assign rx_error_irq = framing_flag && control_reg[`CTL_RX_IRQ_EN];
    assign irq          = |(irq_status & irq_enable);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_empty_q <= 1'b1;
        else
            tx_empty_q <= tx_buf_empty;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status <= 3'h0;
        else
            irq_status <= (irq_status
                & ~((wr_acc && hit(paddr, `OFF_IRQ_CLR)) ? pwdata[2:0] : 3'h0))
                | {rx_done_bad, rx_done_ok, tx_buf_empty && !tx_empty_q};
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lclk_sync <= 2'b00;
            rxd_sync  <= 2'b11;
            lclk_prev <= 1'b0;
        end
        else
        begin
            lclk_sync <= {lclk_sync[0], link_clk};
            rxd_sync  <= {rxd_sync[0], rxd};
            lclk_prev <= lclk_sync[1];
        end
    end

    assign bit_tick = lclk_sync[1] && !lclk_prev;

    ////////////////////////////////////////////////////////////////////////
    // Transmit shifter
    assign tx_load = tx_on && !tx_buf_empty && tx_state == ST_IDLE && bit_tick;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_state   <= ST_IDLE;
            tx_shifter <= 8'h00;
            tx_bits    <= 3'h0;
            txd        <= 1'b1;
        end
        else if (!tx_on)
        begin
            tx_state <= ST_IDLE;
            txd      <= 1'b1;
        end
        else if (bit_tick)
        begin
            case (tx_state)
                ST_IDLE:
                begin
                    txd <= 1'b1;
                    if (tx_load)
                    begin
                        tx_shifter <= tx_holding;
                        tx_bits    <= 3'h0;
                        txd        <= 1'b0;
                        tx_state   <= ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    txd        <= tx_shifter[0];
                    tx_shifter <= {1'b0, tx_shifter[7:1]};
                    tx_bits    <= tx_bits + 3'h1;
                    if (tx_bits == 3'h7)
                        tx_state <= ST_STOP;
                end
                default:
                begin
                    txd      <= 1'b1;
                    tx_state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive shifter
    assign rx_done_ok  = rx_on && bit_tick && rx_state == ST_STOP
                         && rxd_sync[1];
    assign rx_done_bad = rx_on && bit_tick && rx_state == ST_STOP
                         && !rxd_sync[1];
    assign engine_rx_data = rx_holding;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state   <= ST_IDLE;
            rx_shifter <= 8'h00;
            rx_bits    <= 3'h0;
        end
        else if (!rx_on)
            rx_state <= ST_IDLE;
        else if (bit_tick)
        begin
            case (rx_state)
                ST_IDLE:
                begin
                    rx_bits <= 3'h0;
                    if (!rxd_sync[1])
                        rx_state <= ST_DATA;
                end
                ST_DATA:
                begin
                    rx_shifter <= {rxd_sync[1], rx_shifter[7:1]};
                    rx_bits    <= rx_bits + 3'h1;
                    if (rx_bits == 3'h7)
                        rx_state <= ST_STOP;
                end
                default:
                    rx_state <= ST_IDLE;
            endcase
        end
    end

    // Only a good frame reaches the holding register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_holding <= 8'h00;
        else if (rx_done_ok)
            rx_holding <= rx_shifter;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock pin: free-running divided clock, gated by the select bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt <= 16'h0000;
            sck_gen <= 1'b0;
        end
        else if (div_cnt == 16'(CLK_DIV - 1))
        begin
            div_cnt <= 16'h0000;
            sck_gen <= !sck_gen;
        end
        else
            div_cnt <= div_cnt + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_o  <= 1'b0;
            sck_oe <= 1'b0;
        end
        else if (card_mode && gsm_style)
        begin
            sck_oe <= 1'b1;
            sck_o  <= clk_sel[0] ? sck_gen : clk_sel[1];
        end
        else
        begin
            // Reserved 1X codes leave the pin undriven
            sck_oe <= clk_sel == 2'b01;
            sck_o  <= (clk_sel == 2'b01) && sck_gen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [2:0] prev_ctl_clk;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_ctl_clk <= 3'h0;
        else
            prev_ctl_clk <= {card_mode && gsm_style, clk_sel};
    end

    tx_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_irq == (tx_buf_empty && control_reg[7]))
        else $error("tx request not gated by enable");
    rx_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !control_reg[6] |-> !rx_irq && !rx_error_irq)
        else $error("rx request not masked");
    tx_off_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !tx_on |=> tx_state == ST_IDLE && txd)
        else $error("transmit active while disabled");
    rx_off_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !rx_on |=> rx_state == ST_IDLE)
        else $error("receive active while disabled");
    clk_normal_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        !prev_ctl_clk[2] && prev_ctl_clk[1:0] != 2'b01 |-> !sck_oe)
        else $error("clock pin driven when disabled");
    gsm_fixed_lvl_a: assert property (@(posedge pclk) disable iff (!presetn)
        prev_ctl_clk[2] && !prev_ctl_clk[0] |-> sck_oe
        && sck_o == prev_ctl_clk[1])
        else $error("gsm fixed level wrong");
    empty_on_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !tx_on |=> tx_buf_empty)
        else $error("empty flag not set while disabled");
    empty_on_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_load |=> tx_buf_empty && tx_state == ST_DATA)
        else $error("empty flag not set on load");
    engine_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        engine_tx_wr && tx_on && !tx_load |=> !tx_buf_empty)
        else $error("engine write did not clear empty");
    full_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done_ok |=> rx_buf_full && rx_holding == $past(rx_shifter))
        else $error("full flag or data wrong");
    full_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(rx_on) && !rx_done_ok && !engine_rx_rd && !wr_acc
        |=> rx_buf_full == $past(rx_buf_full))
        else $error("rx disable changed full flag");
    no_set_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hit(paddr, `OFF_STATUS) && !rx_done_ok && !rx_buf_full
        |=> !rx_buf_full)
        else $error("write set the full flag");

    tx_frame_c: cover property (@(posedge pclk) disable iff (!presetn)
        tx_load ##[1:300] tx_state == ST_STOP);
    rx_good_c: cover property (@(posedge pclk) disable iff (!presetn)
        rx_done_ok);
    rx_bad_c: cover property (@(posedge pclk) disable iff (!presetn)
        rx_done_bad);
    gsm_switch_c: cover property (@(posedge pclk) disable iff (!presetn)
        prev_ctl_clk[2] && $changed(prev_ctl_clk[1:0]));

endmodule : serial_card_ctrl

// >>> serial_card_defines.svh
// Purpose: Offsets, field positions, reset values and timing for the
//          serial control/status block.
// Assumes: 32-bit APB, one register per aligned word.
// Notes:   Included by the block and the testbench.
`ifndef SERIAL_CARD_DEFINES_SVH
`define SERIAL_CARD_DEFINES_SVH

`define OFF_CONTROL    12'h000
`define OFF_STATUS     12'h004
`define OFF_TX_HOLD    12'h008
`define OFF_RX_HOLD    12'h00C
`define OFF_CARD_MODE  12'h010
`define OFF_IRQ_STAT   12'h014
`define OFF_IRQ_EN     12'h018
`define OFF_IRQ_CLR    12'h01C

`define CTL_TX_IRQ_EN  7
`define CTL_RX_IRQ_EN  6
`define CTL_TX_ON      5
`define CTL_RX_ON      4
`define CTL_ADDR_IEN   3
`define CTL_DONE_IEN   2
`define CTL_CLK_HI     1
`define CTL_CLK_LO     0

`define ST_TX_EMPTY    7
`define ST_RX_FULL     6
`define ST_FRAMING     4

`define MODE_CARD_SEL  0
`define MODE_GSM       1

`define IRQ_TX_EMPTY   0
`define IRQ_RX_FULL    1
`define IRQ_RX_ERR     2

`define CONTROL_RESET  8'h00
`define STATUS_RESET   8'h80
`define CLK_DIV_HALF   16

`endif

// >>> serial_card_pkg.sv
// Purpose: Types shared by the serial control/status block.
// Assumes: Constants come from serial_card_defines.svh.
// Notes:   Types only; numbers live in the header.
package serial_card_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_STOP} shift_state_t;
    typedef logic [7:0] byte_t;
endpackage : serial_card_pkg

// >>> serial_peer.sv
// Purpose: Serial peer on the far side of the link: makes the link
//          clock within frames, drives rxd and samples txd.
// Assumes: The block samples rxd on rising edges of link_clk.
// Notes:   Clock stands low between frames; rxd idles high.
module serial_peer
(
    output logic      link_clk,
    output logic      rxd,
    input  wire logic txd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        link_clk = 1'b0;
        rxd = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Twelve link periods, started 1 ns off the bench clock edge so no
    // link edge lands on it; txd sampled just before each rising edge
    task automatic frame(input logic send, input logic [7:0] d,
                         input logic stop, output logic [11:0] seen);
        logic [11:0] bits;
        bits = {2'b11, stop, d, 1'b0};
        #1;
        for (int i = 0; i < 12; i++)
        begin
            rxd = send ? bits[i] : 1'b1;
            #30;
            seen[i] = txd;
            #2;
            link_clk = 1'b1;
            #32;
            link_clk = 1'b0;
        end
        rxd = 1'b1;
    endtask : frame
endmodule : serial_peer

// >>> testbench.sv
// Purpose: Self-checking bench for the serial control/status block.
// Assumes: APB answers with zero wait states but is waited on anyway.
// Notes:   CLK_DIV is cut to 2 so the clock pin toggles quickly.
`include "serial_card_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        link_clk;
    logic        rxd;
    logic        txd;
    logic        sck_o;
    logic        sck_oe;
    logic        engine_tx_wr;
    logic [7:0]  engine_tx_data;
    logic        engine_rx_rd;
    logic [7:0]  engine_rx_data;
    logic        tx_irq;
    logic        rx_irq;
    logic        rx_error_irq;
    logic        irq;
    int          error_cnt;
    int          cmp_count;
    logic [31:0] q;
    logic        e;
    logic [11:0] s;
    logic        moved;
    logic        prev_sck;
    logic [6:0]  ck_tab [9] = '{7'h0E, 7'h20, 7'h2E, 7'h30, 7'h38,
                                7'h64, 7'h6E, 7'h75, 7'h7E};

    serial_card_ctrl #(.CLK_DIV(2)) serial_card_ctrl_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
        .rxd(rxd), .txd(txd), .sck_o(sck_o), .sck_oe(sck_oe),
        .engine_tx_wr(engine_tx_wr), .engine_tx_data(engine_tx_data),
        .engine_rx_rd(engine_rx_rd), .engine_rx_data(engine_rx_data),
        .tx_irq(tx_irq), .rx_irq(rx_irq), .rx_error_irq(rx_error_irq),
        .irq(irq));

    serial_peer serial_peer_i (.link_clk(link_clk), .rxd(rxd), .txd(txd));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // Holds the request until pready is seen high, then releases it
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ends once pready is high; only the watchdog ends a wait that never sees it
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_val(q, exp);
    endtask : rd_chk

    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    task automatic pulse(input logic rd, input logic [7:0] d);
        @(posedge pclk);
        engine_tx_wr <= ~rd;
        engine_rx_rd <= rd;
        engine_tx_data <= d;
        @(posedge pclk);
        engine_tx_wr <= 1'b0;
        engine_rx_rd <= 1'b0;
        settle();
    endtask : pulse

    task automatic tx_frame(input logic [7:0] exp);
        logic [7:0] got;
        int         k;
        serial_peer_i.frame(1'b0, 8'h00, 1'b1, s);
        k = 0;
        for (int i = 11; i >= 0; i--)
            if (s[i] === 1'b0)
                k = i;
        for (int j = 0; j < 8; j++)
            got[j] = (k + 1 + j < 12) ? s[k + 1 + j] : 1'bx;
        chk_val({24'h000000, got}, {24'h000000, exp});
        chk_bit((k < 3) ? s[k + 9] : 1'bx, 1'b1);
    endtask : tx_frame

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #300000;
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        error_cnt = 0;
        cmp_count = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, engine_tx_wr, engine_rx_rd} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        engine_tx_data = 8'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`OFF_CONTROL, 32'h0000_0000);
        rd_chk(`OFF_STATUS, 32'h0000_0080);
        chk_bit(tx_irq, 1'b0);
        rd_chk(12'h020, 32'h0000_0000);
        chk_bit(e, 1'b1);
        apb(1'b1, `OFF_STATUS, 32'h0000_00FF);
        rd_chk(`OFF_STATUS, 32'h0000_0080);
        apb(1'b1, `OFF_CONTROL, 32'h0000_0080);
        settle();
        chk_bit(tx_irq, 1'b1);
        apb(1'b1, `OFF_CONTROL, 32'h0000_0000);
        settle();
        chk_bit(tx_irq, 1'b0);
        // Transmit path: disabled, then status clear, then engine write
        apb(1'b1, `OFF_TX_HOLD, 32'h0000_00A5);
        apb(1'b1, `OFF_STATUS, 32'h0000_0000);
        rd_chk(`OFF_STATUS, 32'h0000_0080);
        serial_peer_i.frame(1'b0, 8'h00, 1'b1, s);
        chk_val({20'h00000, s}, 32'h0000_0FFF);
        apb(1'b1, `OFF_CONTROL, 32'h0000_00A0);
        rd_chk(`OFF_STATUS, 32'h0000_0080);
        apb(1'b1, `OFF_STATUS, 32'h0000_007F);
        settle();
        chk_bit(tx_irq, 1'b0);
        rd_chk(`OFF_STATUS, 32'h0000_0000);
        tx_frame(8'hA5);
        chk_bit(tx_irq, 1'b1);
        pulse(1'b0, 8'h3C);
        chk_bit(tx_irq, 1'b0);
        tx_frame(8'h3C);
        apb(1'b1, `OFF_CONTROL, 32'h0000_0000);
        // Receive path
        serial_peer_i.frame(1'b1, 8'h5A, 1'b1, s);
        rd_chk(`OFF_STATUS, 32'h0000_0080);
        apb(1'b1, `OFF_CONTROL, 32'h0000_0050);
        serial_peer_i.frame(1'b1, 8'h5A, 1'b1, s);
        rd_chk(`OFF_STATUS, 32'h0000_00C0);
        chk_bit(rx_irq, 1'b1);
        rd_chk(`OFF_RX_HOLD, 32'h0000_005A);
        apb(1'b1, `OFF_CONTROL, 32'h0000_0040);
        rd_chk(`OFF_STATUS, 32'h0000_00C0);
        apb(1'b1, `OFF_STATUS, 32'h0000_00BF);
        rd_chk(`OFF_STATUS, 32'h0000_0080);
        chk_bit(rx_irq, 1'b0);
        apb(1'b1, `OFF_CONTROL, 32'h0000_0050);
        serial_peer_i.frame(1'b1, 8'hC3, 1'b1, s);
        chk_val({24'h000000, engine_rx_data}, 32'h0000_00C3);
        pulse(1'b1, 8'h00);
        chk_bit(rx_irq, 1'b0);
        // Framing error and the event interrupt registers
        apb(1'b1, `OFF_IRQ_EN, 32'h0000_0007);
        serial_peer_i.frame(1'b1, 8'h11, 1'b0, s);
        rd_chk(`OFF_STATUS, 32'h0000_0090);
        chk_bit(rx_error_irq, 1'b1);
        chk_bit(irq, 1'b1);
        apb(1'b1, `OFF_CONTROL, 32'h0000_0010);
        settle();
        chk_bit(rx_error_irq, 1'b0);
        rd_chk(`OFF_IRQ_STAT, 32'h0000_0007);
        apb(1'b1, `OFF_IRQ_EN, 32'h0000_0000);
        settle();
        chk_bit(irq, 1'b0);
        apb(1'b1, `OFF_IRQ_EN, 32'h0000_0007);
        apb(1'b1, `OFF_IRQ_CLR, 32'h0000_0007);
        rd_chk(`OFF_IRQ_STAT, 32'h0000_0000);
        chk_bit(irq, 1'b0);
        apb(1'b1, `OFF_CARD_MODE, 32'h0000_0001);
        rd_chk(`OFF_STATUS, 32'h0000_0080);
        // Clock pin table; in card mode bits 3 and 2 are written zero
        for (int t = 0; t < 9; t++)
        begin
            apb(1'b1, `OFF_CARD_MODE, {30'h0, ck_tab[t][6:5]});
            apb(1'b1, `OFF_CONTROL, {27'h0, 3'h4, ck_tab[t][4:3]});
            settle();
            chk_bit(sck_oe, ck_tab[t][2]);
            moved = 1'b0;
            prev_sck = sck_o;
            for (int c = 0; c < 8; c++)
            begin
                @(posedge pclk);
                #1;
                if (ck_tab[t][2] && ck_tab[t][1:0] != 2'h2)
                    chk_bit(sck_o, ck_tab[t][0]);
                if (sck_o !== prev_sck)
                    moved = 1'b1;
                prev_sck = sck_o;
            end
            if (ck_tab[t][1:0] == 2'h2)
                chk_bit(moved, 1'b1);
        end
        give_verdict();
    end
endmodule : testbench
